/* shared/tpp_pkg.sv */
// Constants and types shared by the power path sequencer
// What this block does
// R1 - Source role: assert source power enable within 200 ms of sink attach, debounce included.
// R2 - Source role with Ra: turn VCONN on within 2 ms after source enable.
// R3 - Source role: drop source power enable within 0.5 ms of sink detach.
// R4 - Source role: open VCONN switch within 1 ms of sink detach.
// R5 - Host VCONN discharge command completes within 30 ms.
// R6 - Source role: VBUS discharge until safe zero (650 ms) or safe five (275 ms).
// R7 - Sink role: below 17 V on detach, drop sink enable, discharge within same limits.
// R8 - Unattached dual role: toggle source/sink, cycle 50-100 ms, source at most 70 percent.
// R9 - Stay in try-source no longer than 150 ms.
// R10 - Each termination change while toggling completes within 1 ms.
// R11 - Fault control on: VCONN short to ground current-limits within 10 us.
// R12 - Fault control on: over-temperature turns VCONN off within 10 us.
// R13 - Reverse voltage fault debounced 46 us, VCONN off within 100 us.
// R14 - After over-temperature trip, retry VCONN after 450 to 650 ms.
// R15 - VCONN current limit selectable among 150, 300, 450 and 600 mA.
// R16 - All intervals counted from the event on one clock, limits set at build time.
// R17 - Each VCONN fault type latched in a host-readable flag until host clears it; short and over-temperature flags latch only with fault control on.
package tpp_pkg;
  localparam int unsigned ClkMhz = 100;
  localparam int unsigned TickUs = 1;
  localparam int unsigned TickCycles = TickUs * ClkMhz;
  localparam int unsigned CntW = 20;
  // Intervals in microseconds, tick counts of one microsecond
  localparam int unsigned AttachDebUs = 150000;
  localparam int unsigned SrcOnMaxUs = 200000;
  localparam int unsigned VconnOnUs = 1000;
  localparam int unsigned VconnDisUs = 20000;
  localparam int unsigned Safe0Us = 650000;
  localparam int unsigned Safe5Us = 275000;
  localparam int unsigned DrpSrcUs = 35000;
  localparam int unsigned DrpSnkUs = 35000;
  localparam int unsigned TryUs = 120000;
  localparam int unsigned RvpDebUs = 46;
  localparam int unsigned OtpRetryUs = 550000;
  // Current limit codes
  localparam logic [1:0] Ilim150 = 2'h0;
  localparam logic [1:0] Ilim300 = 2'h1;
  localparam logic [1:0] Ilim450 = 2'h2;
  localparam logic [1:0] Ilim600 = 2'h3;

  typedef enum logic [2:0] {
    StUnatt = 3'b000,
    StTrySrc = 3'b001,
    StSrcDeb = 3'b010,
    StSrcOn = 3'b011,
    StSnkOn = 3'b100,
    StDischg = 3'b101
  } tpp_state_e;
endpackage : tpp_pkg

/* shared/tpp_tmr_if.sv */
// Interval timer handshake between the sequencer and its timer
`timescale 1ns/1ps
`default_nettype none
interface tpp_tmr_if;
  logic start;
  logic [tpp_pkg::CntW-1:0] limit;
  logic tick;
  logic done;
  modport ctl (output start, output limit, output tick, input done);
  modport tmr (input start, input limit, input tick, output done);
endinterface : tpp_tmr_if
`default_nettype wire

/* rtl/tpp_timer.sv */
// Restartable microsecond interval timer
`timescale 1ns/1ps
`default_nettype none
module tpp_timer (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset
  tpp_tmr_if.tmr t // Start and expiry handshake
);
  import tpp_pkg::*;
  logic [CntW-1:0] cnt_q;
  logic run_q;
  wire expire = run_q && t.tick && (cnt_q + 20'h1 >= t.limit);
  assign t.done = expire;
  always_ff @(posedge mclk) begin
    if (!rst_n || t.start) begin
      cnt_q <= '0; // R16
      run_q <= rst_n;
    end else if (expire) begin
      run_q <= 1'b0;
    end else if (run_q && t.tick) begin
      cnt_q <= cnt_q + 20'h1;
    end
  end
endmodule : tpp_timer
`default_nettype wire

/* rtl/tpp_sequencer.sv */
// Type-C attach, detach, toggling and VCONN fault sequencer
`timescale 1ns/1ps
`default_nettype none
module tpp_sequencer #(
  parameter int unsigned AttachDebUsP = tpp_pkg::AttachDebUs,
  parameter int unsigned Safe0UsP = tpp_pkg::Safe0Us,
  parameter int unsigned Safe5UsP = tpp_pkg::Safe5Us,
  parameter int unsigned DrpSrcUsP = tpp_pkg::DrpSrcUs,
  parameter int unsigned DrpSnkUsP = tpp_pkg::DrpSnkUs,
  parameter int unsigned TryUsP = tpp_pkg::TryUs,
  parameter int unsigned VconnDisUsP = tpp_pkg::VconnDisUs,
  parameter int unsigned OtpRetryUsP = tpp_pkg::OtpRetryUs,
  parameter int unsigned VconnOnUsP = tpp_pkg::VconnOnUs
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst_n, // Synchronous reset, low active
  input wire logic drpEnable, // Dual role toggling allowed
  input wire logic sinkSeen, // Rd seen on CC while advertising source
  input wire logic sourceSeen, // Rp seen on CC while advertising sink
  input wire logic raSeen, // Ra on the unused CC pin
  input wire logic vbusAboveFive, // VBUS above the safe five volt level
  input wire logic vbusSafeZero, // VBUS below the safe zero level
  input wire logic vbusBelowDisc, // VBUS below the sink disconnect level
  input wire logic vconnDischgCmd, // Host VCONN discharge command
  input wire logic hwFaultEn, // Hardware fault control enabled
  input wire logic shortFault, // VCONN short to ground comparator
  input wire logic otpFault, // Over-temperature comparator
  input wire logic reverse_voltage_fault, // Reverse voltage comparator
  input wire logic [1:0] ilimSel, // VCONN current limit select
  input wire logic faultClr, // Host clears all fault flags
  output logic source_power_enable, // Source VBUS FET enable
  output logic sink_power_enable, // Sink VBUS FET enable
  output logic advertiseSrc, // Rp presented, else Rd
  output logic vconnOn, // VCONN switch closed
  output logic vconnLimiting, // VCONN switch in current limit
  output logic [1:0] vconnIlim, // Applied VCONN current limit code
  output logic vbusDischg, // VBUS discharge path on
  output logic vconnDischg, // VCONN discharge path on
  output logic shortFlag, // Latched short fault
  output logic otpFlag, // Latched over-temperature fault
  output logic rvpFlag // Latched reverse voltage fault
);
  import tpp_pkg::*;

  // ==========================================================
  // Input synchronisers
  localparam int NIn = 12;
  logic [NIn-1:0] s1_q, s2_q;
  always_ff @(posedge mclk) begin
    s1_q <= {drpEnable, sinkSeen, sourceSeen, raSeen, vbusAboveFive, vbusSafeZero,
             vbusBelowDisc, vconnDischgCmd, shortFault, otpFault, reverse_voltage_fault,
             faultClr};
    s2_q <= s1_q;
  end
  wire drpS = s2_q[11];
  wire sinkS = s2_q[10];
  wire srcS = s2_q[9];
  wire raS = s2_q[8];
  wire above5S = s2_q[7];
  wire safe0S = s2_q[6];
  wire belowDiscS = s2_q[5];
  wire dischCmdS = s2_q[4];
  wire shortS = s2_q[3];
  wire otpS = s2_q[2];
  wire rvpS = s2_q[1];
  wire clrS = s2_q[0];
  logic dischCmdOld_q;

  // ==========================================================
  // Microsecond tick from one clock
  logic [6:0] div_q;
  logic tick_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || div_q == 7'(TickCycles - 1)) div_q <= '0;
    else div_q <= div_q + 7'h1;
    tick_q <= rst_n && div_q == 7'(TickCycles - 1); // R16
  end

  // ==========================================================
  // State machine and its timer
  tpp_tmr_if st ();
  tpp_timer u_stTmr (.mclk(mclk), .rst_n(rst_n), .t(st));
  tpp_state_e state_q, state_d;
  logic startSt_d;
  logic [CntW-1:0] limSt_d, limSt_q;
  logic advSrc_q;
  logic snkArmed_q;
  assign st.tick = tick_q;
  wire inSrcOn = state_q == StSrcOn;

  always_comb begin
    state_d = state_q;
    startSt_d = 1'b0;
    limSt_d = limSt_q;
    unique case (state_q)
      StUnatt: begin
        if (advSrc_q && sinkS) begin
          state_d = StSrcDeb; startSt_d = 1'b1; limSt_d = CntW'(AttachDebUsP);
        end else if (!advSrc_q && srcS) begin
          if (drpS) begin // Try source before settling as sink
            state_d = StTrySrc; startSt_d = 1'b1; limSt_d = CntW'(TryUsP);
          end else begin
            state_d = StSnkOn;
          end
        // Kept re-armed while toggling is off, so enabling it starts a phase
        end else if (st.done || !drpS) begin // R8
          startSt_d = 1'b1;
          limSt_d = advSrc_q ? CntW'(DrpSnkUsP) : CntW'(DrpSrcUsP);
        end
      end
      StTrySrc: begin
        if (sinkS) begin
          state_d = StSrcDeb; startSt_d = 1'b1; limSt_d = CntW'(AttachDebUsP);
        end else if (st.done) begin
          state_d = StSnkOn; // R9
        end
      end
      StSrcDeb: begin
        if (!sinkS) begin
          state_d = StUnatt; startSt_d = 1'b1; limSt_d = CntW'(DrpSrcUsP);
        end else if (st.done) begin
          state_d = StSrcOn; // R1
        end
      end
      StSrcOn: begin
        if (!sinkS) begin // R3
          state_d = StDischg; startSt_d = 1'b1;
          limSt_d = above5S ? CntW'(Safe5UsP) : CntW'(Safe0UsP); // R6
        end
      end
      StSnkOn: begin
        // Rp lags the switch to Rd by the synchroniser, so loss counts once seen
        if (belowDiscS || (snkArmed_q && !srcS)) begin // R7
          state_d = StDischg; startSt_d = 1'b1;
          limSt_d = above5S ? CntW'(Safe5UsP) : CntW'(Safe0UsP);
        end
      end
      StDischg: begin
        if (safe0S || st.done) begin // R6
          state_d = StUnatt; startSt_d = 1'b1; limSt_d = CntW'(DrpSrcUsP);
        end
      end
      default: state_d = StUnatt;
    endcase
  end
  assign st.start = startSt_d;

  assign st.limit = startSt_d ? limSt_d : limSt_q;
  wire toggleNow = state_q == StUnatt && st.done && drpS;
  wire advSrc_d = (state_d == StTrySrc || state_d == StSrcDeb || state_d == StSrcOn) ? 1'b1 :
                  (state_d == StSnkOn) ? 1'b0 :
                  toggleNow ? !advSrc_q : advSrc_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= StUnatt;
      limSt_q <= '0;
      advSrc_q <= 1'b0;
      snkArmed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      limSt_q <= st.limit;
      advSrc_q <= advSrc_d; // R10
      snkArmed_q <= state_q == StSnkOn && (srcS || snkArmed_q);
    end
  end

  // ==========================================================
  // VCONN enable delay, host discharge, faults
  logic [CntW-1:0] vcCnt_q, disCnt_q, otpCnt_q;
  logic [5:0] rvpCnt_q;
  logic otpOff_q, rvpOff_q, vconnReq_q;
  wire dischCmdEdge = dischCmdS && !dischCmdOld_q;
  wire vcReady = vcCnt_q >= CntW'(VconnOnUsP); // R2
  wire rvpHit = rvpCnt_q >= 6'(RvpDebUs); // R13
  wire otpTrip = hwFaultEn && otpS; // R12
  wire retryDone = otpOff_q && otpCnt_q >= CntW'(OtpRetryUsP); // R14
  wire vconnWant = inSrcOn && raS && vcReady && !otpOff_q && !rvpOff_q && !otpTrip;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vcCnt_q <= '0; disCnt_q <= '0; otpCnt_q <= '0; rvpCnt_q <= '0;
      otpOff_q <= 1'b0; rvpOff_q <= 1'b0; vconnReq_q <= 1'b0; dischCmdOld_q <= 1'b0;
    end else begin
      dischCmdOld_q <= dischCmdS;
      if (!inSrcOn) vcCnt_q <= '0;
      else if (tick_q && !vcReady) vcCnt_q <= vcCnt_q + 20'h1;
      if (dischCmdEdge) disCnt_q <= CntW'(VconnDisUsP); // R5
      else if (tick_q && disCnt_q != '0) disCnt_q <= disCnt_q - 20'h1;
      if (!rvpS) rvpCnt_q <= '0;
      else if (tick_q && !rvpHit) rvpCnt_q <= rvpCnt_q + 6'h1;
      if (rvpHit) rvpOff_q <= 1'b1;
      else if (!inSrcOn) rvpOff_q <= 1'b0;
      if (otpTrip) begin
        otpOff_q <= 1'b1; otpCnt_q <= '0;
      end else if (retryDone) begin
        otpOff_q <= 1'b0;
      end else if (otpOff_q && tick_q) begin
        otpCnt_q <= otpCnt_q + 20'h1;
      end
      vconnReq_q <= vconnWant;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      source_power_enable <= 1'b0; sink_power_enable <= 1'b0; advertiseSrc <= 1'b0;
      vconnOn <= 1'b0; vconnLimiting <= 1'b0; vconnIlim <= Ilim150;
      vbusDischg <= 1'b0; vconnDischg <= 1'b0;
      shortFlag <= 1'b0; otpFlag <= 1'b0; rvpFlag <= 1'b0;
    end else begin
      source_power_enable <= state_d == StSrcOn; // R1 R3
      sink_power_enable <= state_d == StSnkOn; // R7
      advertiseSrc <= advSrc_d; // R8
      vconnOn <= vconnWant && vconnReq_q; // R4
      vconnLimiting <= vconnWant && hwFaultEn && shortS; // R11
      vconnIlim <= ilimSel; // R15
      vbusDischg <= state_d == StDischg; // R6
      vconnDischg <= dischCmdEdge || disCnt_q > 20'h1 || (state_q == StDischg && !vconnOn);
      // Set wins over a same-cycle clear
      shortFlag <= (hwFaultEn && shortS) || (shortFlag && !clrS); // R17
      otpFlag <= otpTrip || (otpFlag && !clrS); // R17
      rvpFlag <= rvpHit || (rvpFlag && !clrS); // R17
    end
  end
endmodule : tpp_sequencer
`default_nettype wire

/* verification/tpp_seq_asserts.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module tpp_seq_asserts #(
  parameter int unsigned Safe0UsP = 650000
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, low active
  input wire logic sinkSeen, // Rd seen
  input wire logic hwFaultEn, // Fault control on
  input wire logic shortFault, // Short comparator
  input wire logic otpFault, // Overheat comparator
  input wire logic reverse_voltage_fault, // Reverse comparator
  input wire logic faultClr, // Flag clear
  input wire logic vconnDischgCmd, // Discharge command
  input wire logic source_power_enable, // Source enable
  input wire logic vconnOn, // VCONN switch
  input wire logic vconnLimiting, // Current limit active
  input wire logic vbusDischg, // VBUS discharge
  input wire logic vconnDischg, // VCONN discharge
  input wire logic shortFlag, // Short flag
  input wire logic otpFlag, // Overheat flag
  input wire logic rvpFlag, // Reverse flag
  input wire logic [1:0] ilimSel, // Limit select
  input wire logic [1:0] vconnIlim // Applied limit code
);
  localparam int VbMax = Safe0UsP * 100 + 200;
  int unsigned rvCnt, vbCnt, clrAge;
  // ========================================
  // Helper counters, unreset: fault and discharge ages restart at zero when low, clrAge on a clear
  always_ff @(posedge mclk) begin
    rvCnt <= reverse_voltage_fault ? rvCnt + 1 : 0;
    vbCnt <= vbusDischg ? vbCnt + 1 : 0;
    clrAge <= faultClr ? 0 : clrAge + (clrAge < 9);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_srcOff; $fell(sinkSeen) && source_power_enable |-> ##[1:8] !source_power_enable;
  endproperty
  a_srcOff: assert property (p_srcOff) else $error("source enable held after detach");
  property p_vcOff; $fell(sinkSeen) && vconnOn |-> ##[1:8] !vconnOn; endproperty
  a_vcOff: assert property (p_vcOff) else $error("vconn held after detach");
  property p_short; hwFaultEn && shortFault && vconnOn |-> ##[1:1000] vconnLimiting; endproperty
  a_short: assert property (p_short) else $error("short not limited in time");
  property p_otp; hwFaultEn && otpFault |-> ##[1:1000] !vconnOn; endproperty
  a_otp: assert property (p_otp) else $error("overheat not switched off");
  property p_rvpOff; rvCnt == 10000 |-> !vconnOn && rvpFlag; endproperty
  a_rvpOff: assert property (p_rvpOff) else $error("reverse fault not handled");
  property p_rvpDeb; rvCnt inside {[1:4500]} |-> !$fell(vconnOn); endproperty
  a_rvpDeb: assert property (p_rvpDeb) else $error("reverse fault not debounced");
  property p_flag; $fell(shortFlag) || $fell(otpFlag) || $fell(rvpFlag) |-> clrAge < 8;
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag lost without clear");
  property p_ilim; $stable(ilimSel) [*6] |-> vconnIlim == ilimSel; endproperty
  a_ilim: assert property (p_ilim) else $error("current limit code wrong");
  property p_vdis; $rose(vconnDischgCmd) |-> ##[1:8] vconnDischg; endproperty
  a_vdis: assert property (p_vdis) else $error("vconn discharge not started");
  property p_vbus; vbCnt <= VbMax; endproperty
  a_vbus: assert property (p_vbus) else $error("vbus discharge too long");
  c_vcOn: cover property ($rose(vconnOn));
  c_detach: cover property ($fell(source_power_enable));
  c_rvp: cover property ($rose(rvpFlag));
endmodule : tpp_seq_asserts
bind tpp_sequencer tpp_seq_asserts #(.Safe0UsP(Safe0UsP)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .sinkSeen(sinkSeen), .hwFaultEn(hwFaultEn), .shortFault(shortFault), .otpFault(otpFault),
  .reverse_voltage_fault(reverse_voltage_fault), .faultClr(faultClr),
  .vconnDischgCmd(vconnDischgCmd), .source_power_enable(source_power_enable),
  .vconnOn(vconnOn), .vconnLimiting(vconnLimiting), .vbusDischg(vbusDischg),
  .vconnDischg(vconnDischg), .shortFlag(shortFlag), .otpFlag(otpFlag), .rvpFlag(rvpFlag),
  .ilimSel(ilimSel), .vconnIlim(vconnIlim));
`default_nettype wire

/* verification/tpp_partner.sv */
// Port partner model on CC and VBUS
`timescale 1ns/1ps
`default_nettype none
module tpp_partner (
  input wire logic mclk, // Clock
  input wire logic snkOn, // Partner shows Rd
  input wire logic withRa, // Cable shows Ra
  input wire logic srcRp, // Partner shows Rp
  input wire logic srcPwr, // Partner drives VBUS high
  input wire logic advertiseSrc, // Block shows Rp
  input wire logic source_power_enable, // Block sources VBUS
  input wire logic vbusDischg, // Block discharges VBUS
  output logic sinkSeen, // Rd seen
  output logic sourceSeen, // Rp seen
  output logic raSeen, // Ra seen
  output logic vbusAboveFive, // Above safe five
  output logic vbusSafeZero, // Below safe zero
  output logic vbusBelowDisc // Below disconnect level
);
  int vbus = 0;
  // ========================================
  // VBUS in mV; bleeds slowly when undriven
  always_ff @(negedge mclk) begin
    if (srcPwr) vbus <= 20000;
    else if (source_power_enable) vbus <= 5000;
    else if (vbusDischg) vbus <= (vbus > 8) ? vbus - 8 : 0;
    else if (vbus > 0) vbus <= vbus - 1;
  end
  // Terminations only show against the opposite pull
  assign sinkSeen = snkOn && advertiseSrc;
  assign raSeen = snkOn && withRa && advertiseSrc;
  assign sourceSeen = srcRp && !advertiseSrc;
  assign vbusAboveFive = vbus > 5500;
  assign vbusSafeZero = vbus < 800;
  assign vbusBelowDisc = vbus < 17000;
endmodule : tpp_partner
`default_nettype wire

/* verification/typec_power_path_sequencer_bench.sv */
// Scenario testbench for the power path sequencer
`timescale 1ns/1ps
`default_nettype none
module typec_power_path_sequencer_bench;
  import tpp_pkg::*;
  localparam int Deb = 20, S0 = 60, S5 = 30, Drp = 20, Try = 30, Vd = 20, Otp = 50, Von = 10;
  logic mclk = 0, rst_n = 0, drpEnable = 0, vconnDischgCmd = 0, hwFaultEn = 0, faultClr = 0;
  logic shortFault = 0, otpFault = 0, reverse_voltage_fault = 0;
  logic snkOn = 0, withRa = 0, srcRp = 0, srcPwr = 0;
  logic [1:0] ilimSel = 2'h0, vconnIlim;
  logic sinkSeen, sourceSeen, raSeen, vbusAboveFive, vbusSafeZero, vbusBelowDisc;
  logic source_power_enable, sink_power_enable, advertiseSrc, vconnOn, vconnLimiting;
  logic vbusDischg, vconnDischg, shortFlag, otpFlag, rvpFlag;
  int num_errors = 0, tests_run = 0, n, t;
  tpp_sequencer #(.AttachDebUsP(Deb), .Safe0UsP(S0), .Safe5UsP(S5), .DrpSrcUsP(Drp),
    .DrpSnkUsP(Drp), .TryUsP(Try), .VconnDisUsP(Vd), .OtpRetryUsP(Otp), .VconnOnUsP(Von))
    dut (.mclk(mclk),
    .rst_n(rst_n), .drpEnable(drpEnable), .sinkSeen(sinkSeen), .sourceSeen(sourceSeen),
    .raSeen(raSeen), .vbusAboveFive(vbusAboveFive), .vbusSafeZero(vbusSafeZero),
    .vbusBelowDisc(vbusBelowDisc), .vconnDischgCmd(vconnDischgCmd), .hwFaultEn(hwFaultEn),
    .shortFault(shortFault), .otpFault(otpFault), .reverse_voltage_fault(reverse_voltage_fault),
    .ilimSel(ilimSel), .faultClr(faultClr), .source_power_enable(source_power_enable),
    .sink_power_enable(sink_power_enable), .advertiseSrc(advertiseSrc), .vconnOn(vconnOn),
    .vconnLimiting(vconnLimiting), .vconnIlim(vconnIlim), .vbusDischg(vbusDischg),
    .vconnDischg(vconnDischg), .shortFlag(shortFlag), .otpFlag(otpFlag), .rvpFlag(rvpFlag));
  tpp_partner u_partner (.mclk(mclk), .snkOn(snkOn), .withRa(withRa), .srcRp(srcRp),
    .srcPwr(srcPwr), .advertiseSrc(advertiseSrc), .source_power_enable(source_power_enable),
    .vbusDischg(vbusDischg), .sinkSeen(sinkSeen), .sourceSeen(sourceSeen), .raSeen(raSeen),
    .vbusAboveFive(vbusAboveFive), .vbusSafeZero(vbusSafeZero), .vbusBelowDisc(vbusBelowDisc));
  // ========================================
  // Shared helpers
  task automatic check(input string what, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check
  task automatic chk_bit(input string what, input logic [1:0] exp, input logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // Counts falling edges until the level shows, bounded
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_for
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // ========================================
  // Scenarios
  task automatic t_drp;
    drpEnable = 1;
    wait_for(advertiseSrc, 1, 9000);
    wait_for(advertiseSrc, 0, 9000);
    t = n;
    wait_for(advertiseSrc, 1, 9000);
    check("source phase", Drp * 100 - 100, Drp * 100 + 100, t);
    check("duty x10", 1, (t + n) * 7, t * 10);
  endtask : t_drp
  task automatic t_source;
    snkOn = 1;
    withRa = 1;
    wait_for(source_power_enable, 1, 9000);
    check("attach to enable", Deb * 100 - 100, (Deb + 2 * Drp) * 100 + 500, n);
    wait_for(vconnOn, 1, 9000);
    check("enable to vconn", Von * 90, Von * 200, n);
    for (int i = 0; i < 4; i++) begin
      ilimSel = i[1:0];
      repeat (6) @(negedge mclk);
      chk_bit("ilim code", i[1:0], vconnIlim);
    end
    hwFaultEn = 1;
    shortFault = 1;
    wait_for(vconnLimiting, 1, 1000);
    check("short response", 0, 999, n);
    shortFault = 0;
    otpFault = 1;
    wait_for(vconnOn, 0, 1000);
    check("otp response", 0, 999, n);
    otpFault = 0;
    wait_for(vconnOn, 1, 9000);
    check("otp retry", Otp * 900 / 11, Otp * 1300 / 11, n);
    chk_bit("latched faults", 2'h3, {shortFlag, otpFlag});
    faultClr = 1;
    repeat (6) @(negedge mclk);
    faultClr = 0;
    chk_bit("cleared faults", 2'h0, {shortFlag, otpFlag});
    snkOn = 0;
    wait_for(source_power_enable, 0, 100000);
    t = n;
    check("detach to disable", 0, 49999, n);
    wait_for(vconnOn, 0, 100000);
    check("detach to vconn off", 0, 99999, t + n);
    wait_for(vbusDischg, 1, 50);
    wait_for(vbusDischg, 0, S0 * 100 + 500);
    check("discharge time", 1, S0 * 100 + 200, n);
    chk_bit("safe zero", 2'h1, vbusSafeZero);
  endtask : t_source
  task automatic t_rvp;
    snkOn = 1;
    wait_for(vconnOn, 1, 220000);
    reverse_voltage_fault = 1;
    wait_for(vconnOn, 0, 20000);
    check("reverse fault off", 4500, 9999, n);
    // Hold the fault past 100 us so the checker sees the whole window
    repeat (5600) @(negedge mclk);
    reverse_voltage_fault = 0;
    chk_bit("reverse flag", 2'h1, rvpFlag);
    snkOn = 0;
    wait_for(vbusDischg, 1, 50);
    wait_for(vbusDischg, 0, S0 * 100 + 500);
  endtask : t_rvp
  task automatic t_sink;
    srcRp = 1;
    srcPwr = 1;
    // Sink phase of the toggle, then the try-source detour
    wait_for(advertiseSrc, 0, 9000);
    wait_for(advertiseSrc, 1, 50);
    wait_for(advertiseSrc, 0, 9000);
    check("try source stay", Try * 100 - 100, Try * 125, n);
    wait_for(sink_power_enable, 1, 9000);
    chk_bit("sink enable", 2'h1, sink_power_enable);
    srcPwr = 0;
    wait_for(vbusBelowDisc, 1, 5000);
    srcRp = 0;
    wait_for(sink_power_enable, 0, 50);
    check("sink enable drop", 0, 49, n);
    wait_for(vbusDischg, 1, 50);
    wait_for(vbusDischg, 0, S5 * 100 + 500);
    check("sink discharge", 1, S5 * 100 + 200, n);
    chk_bit("below safe five", 2'h0, vbusAboveFive);
  endtask : t_sink
  task automatic t_vdis;
    vconnDischgCmd = 1;
    wait_for(vconnDischg, 1, 20);
    vconnDischgCmd = 0;
    wait_for(vconnDischg, 0, Vd * 200);
    check("vconn discharge", 1, Vd * 150, n);
  endtask : t_vdis
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Scenarios need about half of this span
  initial begin
    #800000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1;
    t_drp();
    t_source();
    t_rvp();
    t_sink();
    t_vdis();
    end_of_test();
  end
endmodule : typec_power_path_sequencer_bench
`default_nettype wire
